// >>> src/main_flag_mode_regs.vh
// Register addresses, bit positions and reset values of the main flag, mode and regulator block.
`ifndef MAIN_FLAG_MODE_REGS_VH
`define MAIN_FLAG_MODE_REGS_VH

`define ADDR_W            6
`define DATA_W            16
`define NUM_RAILS         7
`define ADDR_EVENT_FLAGS  6'h00
`define ADDR_MODE_CTRL    6'h01
`define ADDR_REG_REQ      6'h02

// Data bits are numbered as printed (bit 23 down to bit 8); bit 8 maps to data[0].
`define BIT_BASE          8
`define FLG_COMM_FAULT    15
`define FLG_WAKE          14
`define FLG_PREREG        13
`define FLG_STEPUP        12
`define FLG_SD1           11
`define FLG_SD2           10
`define FLG_SD3           9
`define FLG_LIN1          8
`define FLG_LIN2          7
`define FLG_CRC           1
`define FLG_ACCESS        0

`define MODE_PLL_LOCK     8
`define MODE_EXT_SEL      7
`define MODE_EXT_DIS      6
`define MODE_NORMAL       5
`define MODE_WAKE_PIN_TWO_BLK    2
`define MODE_WAKE_PIN_ONE_BLK    1
`define MODE_STBY         0

`define REQ_PD_OFF        15
`define REQ_OFF_LSB       8
`define REQ_ON_LSB        0

`define RST_NORMAL        1'b1
`define RST_BIT           1'b0
`define ZERO_WORD         16'h0000
`define ZERO_RAILS        7'h00

`endif

// >>> src/rail_request_pulse.v
// Per-rail on/off request pulse generator with disable priority.
`include "main_flag_mode_regs.vh"

module rail_request_pulse (
  // Clock and reset
  input  wire                    clock_i,
  input  wire                    reset_i,
  // Write strobe and requested bits
  input  wire                    wr_i,
  input  wire [`NUM_RAILS-1:0]   on_bits_i,
  input  wire [`NUM_RAILS-1:0]   off_bits_i,
  // Pulses
  output reg  [`NUM_RAILS-1:0]   on_pulse_o,
  output reg  [`NUM_RAILS-1:0]   off_pulse_o
);

  genvar g;
  generate
    for (g = 0; g < `NUM_RAILS; g = g + 1) begin : rail
      always @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
          on_pulse_o[g]  <= `RST_BIT;
          off_pulse_o[g] <= `RST_BIT;
        end else begin
          off_pulse_o[g] <= wr_i & off_bits_i[g];
          on_pulse_o[g]  <= wr_i & on_bits_i[g] & ~off_bits_i[g];
        end
      end
    end
  endgenerate

endmodule

// >>> src/main_flag_mode_regctrl_regs.v
// Main-domain flag, mode and regulator request registers behind the I2C register port.
`include "main_flag_mode_regs.vh"

module main_flag_mode_regctrl_regs (
  // Clock and reset
  input  wire                    clock_i,
  input  wire                    reset_i,
  // Register port from the I2C frame decoder
  input  wire                    reg_wr_i,
  input  wire                    reg_rd_i,
  input  wire [`ADDR_W-1:0]      reg_addr_i,
  input  wire [`DATA_W-1:0]      reg_wdata_i,
  output reg  [`DATA_W-1:0]      reg_rdata_o,
  output reg                     reg_rvalid_o,
  // Communication error events
  input  wire                    crc_error_event_i,
  input  wire                    access_violation_event_i,
  input  wire                    failsafe_comm_summary_i,
  // Individual event flags
  input  wire                    wake_input1_flag_i,
  input  wire                    wake_input2_flag_i,
  input  wire                    prereg_overcurrent_i,
  input  wire                    prereg_undervolt_high_i,
  input  wire                    prereg_undervolt_low_i,
  input  wire                    prereg_feedback_overvolt_i,
  input  wire                    stepup_overtemp_i,
  input  wire                    stepup_overvolt_i,
  input  wire                    stepdown1_overcurrent_i,
  input  wire                    stepdown1_overtemp_i,
  input  wire                    stepdown2_overcurrent_i,
  input  wire                    stepdown2_overtemp_i,
  input  wire                    stepdown3_overcurrent_i,
  input  wire                    stepdown3_overtemp_i,
  input  wire                    linear1_overcurrent_i,
  input  wire                    linear1_overtemp_i,
  input  wire                    linear2_overcurrent_i,
  input  wire                    linear2_overtemp_i,
  // Live status
  input  wire                    pll_locked_live_i,
  input  wire                    ext_sync_selected_live_i,
  input  wire                    main_fsm_in_normal_i,
  // Mode controls
  output reg                     ext_sync_disable_req_o,
  output reg                     standby_request_o,
  output reg                     wake_input1_block_o,
  output reg                     wake_input2_block_o,
  // Regulator controls, rail order: pre-reg, boost, step-down 1..3, linear 1..2 (msb first)
  output reg                     prereg_pulldown_off_o,
  output wire [`NUM_RAILS-1:0]   rail_on_req_o,
  output wire [`NUM_RAILS-1:0]   rail_off_req_o,
  // Status
  output reg                     main_crc_error_flag_o,
  output reg                     main_access_violation_flag_o
);

  reg                  crc_flag_ff;
  reg                  access_flag_ff;
  reg                  wake_pin_one_block_ff;
  reg                  wake_pin_two_block_ff;
  reg                  pd_off_ff;
  reg                  normal_ff;
  reg                  nxt_crc_flag;
  reg                  nxt_access_flag;
  reg [`DATA_W-1:0]    nxt_rdata;
  reg [`DATA_W-1:0]    flags_word;
  reg [`DATA_W-1:0]    mode_word;
  reg [`DATA_W-1:0]    req_word;

  wire wr_flags = reg_wr_i & (reg_addr_i == `ADDR_EVENT_FLAGS);
  wire wr_mode  = reg_wr_i & (reg_addr_i == `ADDR_MODE_CTRL);
  wire wr_req   = reg_wr_i & (reg_addr_i == `ADDR_REG_REQ);

  // Clear requests carried by a write of one to the error flag bits.
  wire clr_crc    = wr_flags & reg_wdata_i[`FLG_CRC];
  wire clr_access = wr_flags & reg_wdata_i[`FLG_ACCESS];

  // Summary terms are formed live from their sources and never stored, so a
  // summary can only fall once every flag that feeds it has been cleared.
  wire comm_fault_sum = crc_flag_ff | access_flag_ff | failsafe_comm_summary_i;
  wire wake_sum       = wake_input1_flag_i | wake_input2_flag_i;
  wire prereg_sum     = prereg_overcurrent_i | prereg_undervolt_high_i
                        | prereg_undervolt_low_i | prereg_feedback_overvolt_i;
  wire stepup_sum     = stepup_overtemp_i | stepup_overvolt_i;
  wire sd1_sum        = stepdown1_overcurrent_i | stepdown1_overtemp_i;
  wire sd2_sum        = stepdown2_overcurrent_i | stepdown2_overtemp_i;
  wire sd3_sum        = stepdown3_overcurrent_i | stepdown3_overtemp_i;
  wire lin1_sum       = linear1_overcurrent_i | linear1_overtemp_i;
  wire lin2_sum       = linear2_overcurrent_i | linear2_overtemp_i;

  // A new CRC event overrides a simultaneous clear so that no event is lost.
  always @* begin
    nxt_crc_flag = crc_flag_ff;
    if (clr_crc)
      nxt_crc_flag = 1'b0;
    if (crc_error_event_i)
      nxt_crc_flag = 1'b1;
  end

  // A new access violation overrides a simultaneous clear as well.
  always @* begin
    nxt_access_flag = access_flag_ff;
    if (clr_access)
      nxt_access_flag = 1'b0;
    if (access_violation_event_i)
      nxt_access_flag = 1'b1;
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      crc_flag_ff           <= `RST_BIT;
      main_crc_error_flag_o <= `RST_BIT;
    end else begin
      crc_flag_ff           <= nxt_crc_flag;
      main_crc_error_flag_o <= nxt_crc_flag;
    end
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      access_flag_ff               <= `RST_BIT;
      main_access_violation_flag_o <= `RST_BIT;
    end else begin
      access_flag_ff               <= nxt_access_flag;
      main_access_violation_flag_o <= nxt_access_flag;
    end
  end

  // Normal-mode status is registered once and reads as one after power-on.
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      normal_ff <= `RST_NORMAL;
    end else begin
      normal_ff <= main_fsm_in_normal_i;
    end
  end

  // Mode requests are single-cycle pulses; writing zero produces none.
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      ext_sync_disable_req_o <= `RST_BIT;
      standby_request_o      <= `RST_BIT;
    end else begin
      ext_sync_disable_req_o <= wr_mode & reg_wdata_i[`MODE_EXT_DIS];
      standby_request_o      <= wr_mode & reg_wdata_i[`MODE_STBY];
    end
  end

  // Wake input disables are stored bits mirrored on the outputs.
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      wake_pin_one_block_ff      <= `RST_BIT;
      wake_pin_two_block_ff      <= `RST_BIT;
      wake_input1_block_o <= `RST_BIT;
      wake_input2_block_o <= `RST_BIT;
    end else if (wr_mode) begin
      wake_pin_one_block_ff      <= reg_wdata_i[`MODE_WAKE_PIN_ONE_BLK];
      wake_pin_two_block_ff      <= reg_wdata_i[`MODE_WAKE_PIN_TWO_BLK];
      wake_input1_block_o <= reg_wdata_i[`MODE_WAKE_PIN_ONE_BLK];
      wake_input2_block_o <= reg_wdata_i[`MODE_WAKE_PIN_TWO_BLK];
    end
  end

  // Pre-regulator pull-down control is the only stored bit of the request register.
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      pd_off_ff             <= `RST_BIT;
      prereg_pulldown_off_o <= `RST_BIT;
    end else if (wr_req) begin
      pd_off_ff             <= reg_wdata_i[`REQ_PD_OFF];
      prereg_pulldown_off_o <= reg_wdata_i[`REQ_PD_OFF];
    end
  end

  rail_request_pulse rail_request_pulse_i (
    .clock_i     (clock_i),
    .reset_i     (reset_i),
    .wr_i        (wr_req),
    .on_bits_i   (reg_wdata_i[`REQ_ON_LSB +: `NUM_RAILS]),
    .off_bits_i  (reg_wdata_i[`REQ_OFF_LSB +: `NUM_RAILS]),
    .on_pulse_o  (rail_on_req_o),
    .off_pulse_o (rail_off_req_o)
  );

  // Flag register image; unused bits read as zero.
  always @* begin
    flags_word                 = `ZERO_WORD;
    flags_word[`FLG_COMM_FAULT] = comm_fault_sum;
    flags_word[`FLG_WAKE]      = wake_sum;
    flags_word[`FLG_PREREG]    = prereg_sum;
    flags_word[`FLG_STEPUP]    = stepup_sum;
    flags_word[`FLG_SD1]       = sd1_sum;
    flags_word[`FLG_SD2]       = sd2_sum;
    flags_word[`FLG_SD3]       = sd3_sum;
    flags_word[`FLG_LIN1]      = lin1_sum;
    flags_word[`FLG_LIN2]      = lin2_sum;
    flags_word[`FLG_CRC]       = crc_flag_ff;
    flags_word[`FLG_ACCESS]    = access_flag_ff;
  end

  // Mode register image; request bits read back as reserved zero.
  always @* begin
    mode_word                  = `ZERO_WORD;
    mode_word[`MODE_PLL_LOCK]  = pll_locked_live_i;
    mode_word[`MODE_EXT_SEL]   = ext_sync_selected_live_i;
    mode_word[`MODE_NORMAL]    = normal_ff;
    mode_word[`MODE_WAKE_PIN_TWO_BLK] = wake_pin_two_block_ff;
    mode_word[`MODE_WAKE_PIN_ONE_BLK] = wake_pin_one_block_ff;
  end

  // Request register image: only the pull-down control reads back.
  always @* begin
    req_word              = `ZERO_WORD;
    req_word[`REQ_PD_OFF] = pd_off_ff;
  end

  // Unmapped addresses read as zero.
  always @* begin
    nxt_rdata = `ZERO_WORD;
    case (reg_addr_i)
      `ADDR_EVENT_FLAGS: nxt_rdata = flags_word;
      `ADDR_MODE_CTRL:   nxt_rdata = mode_word;
      `ADDR_REG_REQ:     nxt_rdata = req_word;
      default:           nxt_rdata = `ZERO_WORD;
    endcase
  end

  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rvalid_o <= `RST_BIT;
    end else begin
      reg_rvalid_o <= reg_rd_i;
    end
  end

  // Read data is held until the next read so the host may sample it late.
  always @(posedge clock_i or posedge reset_i) begin
    if (reset_i) begin
      reg_rdata_o <= `ZERO_WORD;
    end else if (reg_rd_i) begin
      reg_rdata_o <= nxt_rdata;
    end
  end

endmodule

// >>> verif/main_flag_mode_regctrl_regs_sva.sv
// Concurrent checks on the ports of the main flag, mode and regulator request block.
`include "main_flag_mode_regs.vh"
module regs_sva_chk (
  // Clock and reset
  input wire logic               clock_i,
  input wire logic               reset_i,
  // Register port
  input wire logic               reg_wr_i,
  input wire logic               reg_rd_i,
  input wire logic [`ADDR_W-1:0] reg_addr_i,
  input wire logic [`DATA_W-1:0] reg_wdata_i,
  input wire logic               reg_rvalid_o,
  // Events and controls
  input wire logic               crc_error_event_i,
  input wire logic               access_violation_event_i,
  input wire logic               ext_sync_disable_req_o,
  input wire logic               standby_request_o,
  input wire logic               wake_input1_block_o,
  input wire logic               wake_input2_block_o,
  input wire logic               prereg_pulldown_off_o,
  input wire logic [6:0]         rail_on_req_o,
  input wire logic [6:0]         rail_off_req_o,
  input wire logic               main_crc_error_flag_o,
  input wire logic               main_access_violation_flag_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire wf = reg_wr_i && reg_addr_i == `ADDR_EVENT_FLAGS;
  wire wm = reg_wr_i && reg_addr_i == `ADDR_MODE_CTRL;
  wire wq = reg_wr_i && reg_addr_i == `ADDR_REG_REQ;
  a_crc_flag_set: assert property (crc_error_event_i |=> main_crc_error_flag_o)
    else $error("crc flag not set by event");
  a_crc_flag_clr: assert property (wf && reg_wdata_i[1] && !crc_error_event_i
    |=> !main_crc_error_flag_o) else $error("crc flag not cleared");
  a_acc_flag_set: assert property (access_violation_event_i |=> main_access_violation_flag_o)
    else $error("access flag not set by event");
  a_acc_flag_hold: assert property (main_access_violation_flag_o && !(wf && reg_wdata_i[0])
    |=> main_access_violation_flag_o) else $error("access flag dropped without clear");
  a_read_valid: assert property (reg_rvalid_o == $past(reg_rd_i))
    else $error("read valid not one cycle after read");
  a_off_pulse: assert property (rail_off_req_o == ($past(wq) ? $past(reg_wdata_i[14:8]) : 7'h00))
    else $error("off request pulse wrong");
  a_on_masked: assert property (wq |=> rail_on_req_o == ($past(reg_wdata_i[6:0])
    & ~$past(reg_wdata_i[14:8]))) else $error("on request pulse wrong");
  a_mode_pulses: assert property ({ext_sync_disable_req_o, standby_request_o} ==
    ($past(wm) ? {$past(reg_wdata_i[6]), $past(reg_wdata_i[0])} : 2'b00))
    else $error("mode request pulse wrong");
  a_wake_blocks: assert property (wm |=> {wake_input2_block_o, wake_input1_block_o} ==
    $past(reg_wdata_i[2:1])) else $error("wake block bits wrong");
  a_pulldown_bit: assert property (wq |=> prereg_pulldown_off_o == $past(reg_wdata_i[15]))
    else $error("pull-down control wrong");
endmodule

bind main_flag_mode_regctrl_regs regs_sva_chk regs_sva_chk_i (.clock_i, .reset_i, .reg_wr_i,
  .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rvalid_o, .crc_error_event_i,
  .access_violation_event_i, .ext_sync_disable_req_o, .standby_request_o, .wake_input1_block_o,
  .wake_input2_block_o, .prereg_pulldown_off_o, .rail_on_req_o, .rail_off_req_o,
  .main_crc_error_flag_o, .main_access_violation_flag_o);

// >>> verif/host_port_model.sv
// Host model issuing single register writes and reads toward the block.
`include "main_flag_mode_regs.vh"
module host_port_model (
  // Clock
  input wire logic                clock_i,
  // Register port
  output logic                    wr_o,
  output logic                    rd_o,
  output logic [`ADDR_W-1:0]      addr_o,
  output logic [`DATA_W-1:0]      wdata_o,
  input wire logic [`DATA_W-1:0]  rdata_i,
  input wire logic                rvalid_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic pre_off = 1'b0;
  initial begin
    {wr_o, rd_o, addr_o, wdata_o} = '0;
  end
  task automatic wr(input logic [`ADDR_W-1:0] a, input logic [`DATA_W-1:0] d);
    if (a == `ADDR_REG_REQ) begin
      pre_off = pre_off | d[14];
      d[6] = d[6] & pre_off;
    end
    @(negedge clock_i);
    {wr_o, addr_o, wdata_o} = {1'b1, a, d};
    @(negedge clock_i);
    wr_o = 1'b0;
    wdata_o = ~d;
  endtask
  task automatic rd(input logic [`ADDR_W-1:0] a, output logic [`DATA_W-1:0] d);
    @(negedge clock_i);
    {rd_o, addr_o} = {1'b1, a};
    @(negedge clock_i);
    rd_o = 1'b0;
    d = (rvalid_i === 1'b1) ? rdata_i : 16'hxxxx;
  endtask
endmodule

// >>> verif/main_flag_mode_regctrl_regs_test.sv
// Self-checking bench for the main flag, mode and regulator request block.
`include "main_flag_mode_regs.vh"
module main_flag_mode_regctrl_regs_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i, reset_i, reg_wr_i, reg_rd_i, crc_error_event_i, access_violation_event_i;
  logic pll_locked_live_i, ext_sync_selected_live_i, main_fsm_in_normal_i, reg_rvalid_o;
  logic [`ADDR_W-1:0] reg_addr_i;
  logic [`DATA_W-1:0] reg_wdata_i, reg_rdata_o;
  logic [18:0] flt;
  logic [6:0] rail_on_req_o, rail_off_req_o;
  logic ext_sync_disable_req_o, standby_request_o, wake_input1_block_o, wake_input2_block_o;
  logic prereg_pulldown_off_o, main_crc_error_flag_o, main_access_violation_flag_o;
  int err_total = 0;
  int checks = 0;
  main_flag_mode_regctrl_regs main_flag_mode_regctrl_regs_i (.clock_i, .reset_i, .reg_wr_i,
    .reg_rd_i, .reg_addr_i, .reg_wdata_i, .reg_rdata_o, .reg_rvalid_o, .crc_error_event_i,
    .access_violation_event_i, .failsafe_comm_summary_i(flt[0]), .wake_input1_flag_i(flt[1]),
    .wake_input2_flag_i(flt[2]), .prereg_overcurrent_i(flt[3]), .prereg_undervolt_high_i(flt[4]),
    .prereg_undervolt_low_i(flt[5]), .prereg_feedback_overvolt_i(flt[6]),
    .stepup_overtemp_i(flt[7]), .stepup_overvolt_i(flt[8]), .stepdown1_overcurrent_i(flt[9]),
    .stepdown1_overtemp_i(flt[10]), .stepdown2_overcurrent_i(flt[11]),
    .stepdown2_overtemp_i(flt[12]), .stepdown3_overcurrent_i(flt[13]),
    .stepdown3_overtemp_i(flt[14]), .linear1_overcurrent_i(flt[15]),
    .linear1_overtemp_i(flt[16]), .linear2_overcurrent_i(flt[17]), .linear2_overtemp_i(flt[18]),
    .pll_locked_live_i, .ext_sync_selected_live_i, .main_fsm_in_normal_i,
    .ext_sync_disable_req_o, .standby_request_o, .wake_input1_block_o,
    .wake_input2_block_o, .prereg_pulldown_off_o, .rail_on_req_o, .rail_off_req_o,
    .main_crc_error_flag_o, .main_access_violation_flag_o);
  host_port_model host_port_model_i (.clock_i, .wr_o(reg_wr_i), .rd_o(reg_rd_i),
    .addr_o(reg_addr_i), .wdata_o(reg_wdata_i), .rdata_i(reg_rdata_o), .rvalid_i(reg_rvalid_o));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  function automatic int sbit(input int i);
    return i == 0 ? 15 : i < 3 ? 14 : i < 7 ? 13 : 12 - (i - 7) / 2;
  endfunction
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdc(input logic [`ADDR_W-1:0] a, input logic [15:0] e);
    logic [15:0] d;
    host_port_model_i.rd(a, d);
    chk("read data", e, d);
  endtask
  // Writes the request register and gathers the pulses that follow.
  task automatic req(input logic [15:0] d, input logic [6:0] eon, input logic [6:0] eoff);
    logic [6:0] son = 7'h00;
    logic [6:0] soff = 7'h00;
    host_port_model_i.wr(`ADDR_REG_REQ, d);
    repeat (3) begin
      son |= rail_on_req_o;
      soff |= rail_off_req_o;
      @(posedge clock_i);
      #1;
    end
    chk("on pulses", {9'h000, eon}, {9'h000, son});
    chk("off pulses", {9'h000, eoff}, {9'h000, soff});
  endtask
  task automatic results;
    if (err_total == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #100us;
    err_total++;
    results();
  end
  initial begin
    {reset_i, crc_error_event_i, access_violation_event_i, flt} = {3'b100, 19'h00000};
    {pll_locked_live_i, ext_sync_selected_live_i, main_fsm_in_normal_i} = 3'b001;
    repeat (10) @(negedge clock_i);
    reset_i = 1'b0;
    rdc(`ADDR_EVENT_FLAGS, 16'h0000);
    rdc(`ADDR_MODE_CTRL, 16'h0020);
    {pll_locked_live_i, ext_sync_selected_live_i, main_fsm_in_normal_i} = 3'b110;
    rdc(`ADDR_MODE_CTRL, 16'h0180);
    for (int i = 0; i < 19; i++) begin
      flt = 19'h00001 << i;
      rdc(`ADDR_EVENT_FLAGS, 16'h0001 << sbit(i));
    end
    flt = 19'h00000;
    rdc(`ADDR_EVENT_FLAGS, 16'h0000);
    for (int j = 0; j < 2; j++) begin
      {crc_error_event_i, access_violation_event_i} = 2'b01 << j;
      @(negedge clock_i);
      {crc_error_event_i, access_violation_event_i} = 2'b00;
      host_port_model_i.wr(`ADDR_EVENT_FLAGS, 16'h0000);
      rdc(`ADDR_EVENT_FLAGS, 16'h8000 | (16'h0001 << j));
      chk("error flags", {14'h0000, 2'b01 << j}, {14'h0000, main_crc_error_flag_o, main_access_violation_flag_o});
      {crc_error_event_i, access_violation_event_i} = 2'b01 << j;
      host_port_model_i.wr(`ADDR_EVENT_FLAGS, 16'h0003);
      {crc_error_event_i, access_violation_event_i} = 2'b00;
      rdc(`ADDR_EVENT_FLAGS, 16'h8000 | (16'h0001 << j));
      host_port_model_i.wr(`ADDR_EVENT_FLAGS, 16'h0003);
      rdc(`ADDR_EVENT_FLAGS, 16'h0000);
      chk("error flags", 16'h0000, {14'h0000, main_crc_error_flag_o, main_access_violation_flag_o});
    end
    host_port_model_i.wr(`ADDR_MODE_CTRL, 16'hffff);
    chk("mode pulses", 16'h0003, {14'h0000, ext_sync_disable_req_o, standby_request_o});
    chk("wake blocks", 16'h0003, {14'h0000, wake_input2_block_o, wake_input1_block_o});
    rdc(`ADDR_MODE_CTRL, 16'h0186);
    host_port_model_i.wr(`ADDR_MODE_CTRL, 16'h0004);
    chk("mode pulses", 16'h0000, {14'h0000, ext_sync_disable_req_o, standby_request_o});
    chk("wake blocks", 16'h0002, {14'h0000, wake_input2_block_o, wake_input1_block_o});
    rdc(`ADDR_MODE_CTRL, 16'h0184);
    req(16'h4040, 7'h00, 7'h40);
    for (int k = 0; k < 7; k++) begin
      req(16'h0100 << k, 7'h00, 7'h01 << k);
      req(16'h0001 << k, 7'h01 << k, 7'h00);
    end
    req(16'hffff, 7'h00, 7'h7f);
    rdc(`ADDR_REG_REQ, 16'h8000);
    chk("pull-down off", 16'h0001, {15'h0000, prereg_pulldown_off_o});
    req(16'h0000, 7'h00, 7'h00);
    rdc(`ADDR_REG_REQ, 16'h0000);
    chk("pull-down off", 16'h0000, {15'h0000, prereg_pulldown_off_o});
    host_port_model_i.wr(6'h3f, 16'hffff);
    rdc(6'h3f, 16'h0000);
    results();
  end
endmodule
